// File: hdl/eeprom_access_controller.sv
// Purpose: AHB-Lite register front end and write timer for the on-chip nonvolatile array.
// Assumes: sleep_power_down and system_reset come from logic on hclk; hresetn is power-on reset.
// Notes: CPU stalls appear as hreadyout held low after a strobe write.
//
// Added by the designer: the address map and the AHB-Lite slave port.
`include "eac_params.svh"

// Summary of operation
// - Read strobe loads the data register from the current address at once.
// - A read holds the CPU for four cycles before the next access.
// - While writing, read strobes are ignored and address writes refused.
// - Writes last 67 584 oscillator cycles of 15 bus clocks each, about 8.1 ms.
// - After a write finishes in power-down, the oscillator keeps running.
// - A system reset during a write lets the write complete.
// - Arm clears four cycles after set; strobe without arm does nothing.
// - Busy clears when time elapses; ready request while clear and enabled.
// - A write strobe holds the CPU for two cycles.
// - Nine-bit linear address 0 to 511; unused upper bits read zero.
module eeprom_access_controller
  import eac_pkg::*;
#(
  parameter int WRITE_OSC_CYCLES = `EAC_WRITE_OSC_CYCLES
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic system_reset,
  input wire logic sleep_power_down,
  output logic cpu_stall,
  output logic osc_run,
  output logic nvm_ready_irq
);

  localparam logic [`EAC_DIV_WIDTH-1:0] OSC_DIV_LAST = `EAC_DIV_WIDTH'(`EAC_OSC_DIV - 1);
  localparam logic [`EAC_OSC_CNT_WIDTH-1:0] PROG_LAST = `EAC_OSC_CNT_WIDTH'(WRITE_OSC_CYCLES - 1);

  logic dp_valid_r;
  logic dp_write_r;
  logic [7:0] dp_addr_r;
  logic [31:0] hrdata_r;
  logic [2:0] stall_cnt_r;
  logic [2:0] arm_cnt_r;
  eac_ctrl_type ctrl_r;
  logic [`EAC_ADDR_WIDTH-1:0] addr_r;
  logic [`EAC_DATA_WIDTH-1:0] data_r;
  eac_wreq_type wreq_r;
  eac_state_type state_r;
  logic [`EAC_DIV_WIDTH-1:0] div_cnt_r;
  logic [`EAC_OSC_CNT_WIDTH-1:0] prog_cnt_r;
  logic osc_hold_r;
  logic [`EAC_DATA_WIDTH-1:0] array_rd;
  logic osc_tick;
  logic busy;
  logic commit;
  logic wr_ctrl;
  logic read_go;
  logic write_go;
  logic arm_set;
  logic [31:0] rd_mux;

  assign busy = (state_r == EAC_PROG);
  assign wr_ctrl = dp_valid_r && dp_write_r && hready && (dp_addr_r == `EAC_OFS_CTRL);
  assign read_go = wr_ctrl && hwdata[`EAC_BIT_READ_STROBE] && !busy;
  assign write_go = wr_ctrl && hwdata[`EAC_BIT_WRITE_STROBE] && ctrl_r.master_write_arm && !busy;
  assign arm_set = wr_ctrl && hwdata[`EAC_BIT_MASTER_ARM] && !ctrl_r.master_write_arm;
  assign osc_tick = busy && (div_cnt_r == OSC_DIV_LAST);
  assign commit = osc_tick && (prog_cnt_r == PROG_LAST);

  assign hreadyout = (stall_cnt_r == 3'h0);
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign cpu_stall = (stall_cnt_r != 3'h0);
  assign osc_run = busy || osc_hold_r;
  assign nvm_ready_irq = ctrl_r.ready_irq_enable && !busy;

  eac_nvm_array u_array (
    .hclk(hclk),
    .wr_en(commit),
    .wr_req(wreq_r),
    .rd_addr(addr_r),
    .rd_data(array_rd)
  );

  // Read mux; the busy bit shows the live write state and the read strobe reads zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (haddr[7:0] == `EAC_OFS_CTRL) begin
      rd_mux[`EAC_BIT_READY_IRQ_EN] = ctrl_r.ready_irq_enable;
      rd_mux[`EAC_BIT_MASTER_ARM] = ctrl_r.master_write_arm;
      rd_mux[`EAC_BIT_WRITE_STROBE] = busy;
    end else if (haddr[7:0] == `EAC_OFS_DATA) begin
      rd_mux[`EAC_DATA_WIDTH-1:0] = data_r;
    end else if (haddr[7:0] == `EAC_OFS_ADDR_LO) begin
      rd_mux[7:0] = addr_r[7:0];
    end else if (haddr[7:0] == `EAC_OFS_ADDR_HI) begin
      rd_mux[0] = addr_r[`EAC_ADDR_WIDTH-1];
    end
  end

  // Address phase capture and registered read data.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
    end else if (hready) begin
      dp_valid_r <= hsel && htrans[1];
      dp_write_r <= hwrite;
      dp_addr_r <= haddr[7:0];
      if (hsel && htrans[1] && !hwrite) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  // Bus stall after a strobe.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stall_cnt_r <= 3'h0;
    end else if (system_reset) begin
      stall_cnt_r <= 3'h0;
    end else if (read_go) begin
      stall_cnt_r <= `EAC_READ_STALL;
    end else if (write_go) begin
      stall_cnt_r <= `EAC_WRITE_STALL;
    end else if (stall_cnt_r != 3'h0) begin
      stall_cnt_r <= stall_cnt_r - 3'h1;
    end
  end

  // Control bits and the arm timeout.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= '0;
      arm_cnt_r <= 3'h0;
    end else if (system_reset) begin
      ctrl_r <= '0;
      arm_cnt_r <= 3'h0;
    end else begin
      ctrl_r.read_strobe <= 1'b0;
      ctrl_r.write_strobe_busy <= 1'b0;
      if (wr_ctrl) begin
        ctrl_r.ready_irq_enable <= hwdata[`EAC_BIT_READY_IRQ_EN];
      end
      if (arm_set) begin
        ctrl_r.master_write_arm <= 1'b1;
        arm_cnt_r <= `EAC_ARM_CYCLES - 3'h1;
      end else if (ctrl_r.master_write_arm) begin
        if (arm_cnt_r == 3'h0) begin
          ctrl_r.master_write_arm <= 1'b0;
        end else begin
          arm_cnt_r <= arm_cnt_r - 3'h1;
        end
      end
    end
  end

  // Address register, frozen during a write.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r <= '0;
    end else if (system_reset) begin
      addr_r <= '0;
    end else if (dp_valid_r && dp_write_r && hready && !busy) begin
      if (dp_addr_r == `EAC_OFS_ADDR_LO) begin
        addr_r[7:0] <= hwdata[7:0];
      end else if (dp_addr_r == `EAC_OFS_ADDR_HI) begin
        addr_r[`EAC_ADDR_WIDTH-1] <= hwdata[0];
      end
    end
  end

  // Data register loads from software or from the array on a read strobe.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_r <= '0;
    end else if (system_reset) begin
      data_r <= '0;
    end else if (read_go) begin
      data_r <= array_rd;
    end else if (dp_valid_r && dp_write_r && hready && (dp_addr_r == `EAC_OFS_DATA)) begin
      data_r <= hwdata[`EAC_DATA_WIDTH-1:0];
    end
  end

  // Write engine; system_reset and sleep do not touch it so a write always completes.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= EAC_IDLE;
      wreq_r <= '0;
      div_cnt_r <= '0;
      prog_cnt_r <= '0;
    end else begin
      case (state_r)
        EAC_IDLE: begin
          div_cnt_r <= '0;
          prog_cnt_r <= '0;
          if (write_go) begin
            wreq_r.addr <= addr_r;
            wreq_r.data <= data_r;
            state_r <= EAC_PROG;
          end
        end
        EAC_PROG: begin
          if (osc_tick) begin
            div_cnt_r <= '0;
            prog_cnt_r <= prog_cnt_r + `EAC_OSC_CNT_WIDTH'(1);
          end else begin
            div_cnt_r <= div_cnt_r + `EAC_DIV_WIDTH'(1);
          end
          if (commit) begin
            state_r <= EAC_IDLE;
          end
        end
        default: begin
          state_r <= EAC_IDLE;
        end
      endcase
    end
  end

  // Oscillator stays on after a write ends inside power-down until sleep is left.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_hold_r <= 1'b0;
    end else if (commit && sleep_power_down) begin
      osc_hold_r <= 1'b1;
    end else if (!sleep_power_down) begin
      osc_hold_r <= 1'b0;
    end
  end

endmodule

// File: hdl/eac_params.svh
// Purpose: Named offsets, field positions and timing counts of the access controller.
// Assumes: A 125 MHz bus clock and a calibrated oscillator of about 8 MHz.
// Notes: Included by the package and the design modules.
`ifndef EAC_PARAMS_SVH
`define EAC_PARAMS_SVH

`define EAC_OFS_CTRL 8'h00
`define EAC_OFS_DATA 8'h04
`define EAC_OFS_ADDR_LO 8'h08
`define EAC_OFS_ADDR_HI 8'h0c

`define EAC_BIT_READ_STROBE 0
`define EAC_BIT_WRITE_STROBE 1
`define EAC_BIT_MASTER_ARM 2
`define EAC_BIT_READY_IRQ_EN 3

`define EAC_ADDR_WIDTH 9
`define EAC_DATA_WIDTH 8
`define EAC_DEPTH 512

`define EAC_READ_STALL 3'h4
`define EAC_WRITE_STALL 3'h2
`define EAC_ARM_CYCLES 3'h4

`define EAC_CLK_PERIOD_NS 8
`define EAC_WRITE_TIME_NS 8500000
`define EAC_WRITE_OSC_CYCLES 67584
`define EAC_OSC_DIV (`EAC_WRITE_TIME_NS / (`EAC_WRITE_OSC_CYCLES * `EAC_CLK_PERIOD_NS))
`define EAC_OSC_CNT_WIDTH 17
`define EAC_DIV_WIDTH 5

`endif

// File: hdl/eac_pkg.sv
// Purpose: Types shared by the access controller and its storage array.
// Assumes: Constants come from the params header.
// Notes: Holds types only.
`include "eac_params.svh"

package eac_pkg;

  typedef struct packed {
    logic ready_irq_enable;
    logic master_write_arm;
    logic write_strobe_busy;
    logic read_strobe;
  } eac_ctrl_type;

  typedef struct packed {
    logic [`EAC_ADDR_WIDTH-1:0] addr;
    logic [`EAC_DATA_WIDTH-1:0] data;
  } eac_wreq_type;

  typedef enum logic [1:0] {
    EAC_IDLE = 2'b00,
    EAC_PROG = 2'b01
  } eac_state_type;

endpackage

// File: hdl/eac_nvm_array.sv
// Purpose: The 512-byte nonvolatile storage array.
// Assumes: One write port committed at the end of programming, one asynchronous read port.
// Notes: Contents are not touched by any reset.
`include "eac_params.svh"

module eac_nvm_array
  import eac_pkg::*;
(
  input wire logic hclk,
  input wire logic wr_en,
  input wire eac_wreq_type wr_req,
  input wire logic [`EAC_ADDR_WIDTH-1:0] rd_addr,
  output logic [`EAC_DATA_WIDTH-1:0] rd_data
);

  logic [`EAC_DATA_WIDTH-1:0] mem_r [0:`EAC_DEPTH-1];

  // Writes land only when programming time has elapsed.
  always_ff @(posedge hclk) begin
    if (wr_en) begin
      mem_r[wr_req.addr] <= wr_req.data;
    end
  end

  assign rd_data = mem_r[rd_addr];

endmodule

// File: testbench/eac_nvm_model.sv
// Purpose: Reference contents of the storage array.
// Assumes: The bench records every write that it starts.
// Notes: Holds the byte that each address must read back as.
module eac_nvm_model;
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:511];
endmodule

// File: testbench/eac_checker_asserts.sv
// Purpose: Checks stalls, write timing and the ready request of the controller.
// Assumes: hready is tied to hreadyout.
// Notes: Bound to the top module.
module eac_checker #(
  parameter int WRITE_OSC_CYCLES = 4
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic system_reset,
  input wire logic sleep_power_down,
  input wire logic osc_run,
  input wire logic nvm_ready_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic dp_v;
  logic dp_wr;
  logic [7:0] dp_a;
  logic ien_r;
  logic slept_r;
  int run_cnt;
  wire logic dp_ctrl = dp_v && dp_wr && dp_a == 8'h00 && hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_v <= 1'b0;
      dp_wr <= 1'b0;
      dp_a <= 8'h00;
    end else if (hready) begin
      dp_v <= hsel && htrans[1];
      dp_wr <= hwrite;
      dp_a <= haddr[7:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ien_r <= 1'b0;
    else if (system_reset) ien_r <= 1'b0;
    else if (dp_ctrl) ien_r <= hwdata[3];
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_cnt <= 0;
      slept_r <= 1'b0;
    end else begin
      run_cnt <= osc_run ? run_cnt + 1 : 0;
      slept_r <= osc_run ? (slept_r || sleep_power_down) : 1'b0;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_rd_stall;
    dp_ctrl && hwdata[0] && !osc_run |=> !hreadyout [*4] ##1 hreadyout;
  endproperty
  a_rd_stall: assert property (p_rd_stall) else $error("read stall length wrong");
  property p_wr_stall;
    $rose(osc_run) |-> !hreadyout [*2] ##1 hreadyout;
  endproperty
  a_wr_stall: assert property (p_wr_stall) else $error("write stall length wrong");
  property p_busy_len;
    $fell(osc_run) && !slept_r |-> run_cnt >= WRITE_OSC_CYCLES * 15 - 1 && run_cnt <= WRITE_OSC_CYCLES * 15 + 2;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write time wrong");
  property p_busy_rd;
    dp_ctrl && hwdata[0] && osc_run && !sleep_power_down |=> hreadyout;
  endproperty
  a_busy_rd: assert property (p_busy_rd) else $error("busy read strobe stalled");
  property p_sleep_run;
    osc_run && sleep_power_down |=> osc_run;
  endproperty
  a_sleep_run: assert property (p_sleep_run) else $error("oscillator stopped in sleep");
  property p_irq_off;
    nvm_ready_irq |-> ien_r;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("ready request without enable");
  property p_irq_on;
    ien_r && !osc_run |-> nvm_ready_irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("ready request missing");
  property p_addr_hi;
    dp_v && !dp_wr && dp_a == 8'h0c && hready |-> hrdata[31:1] == 31'h0;
  endproperty
  a_addr_hi: assert property (p_addr_hi) else $error("upper address bits not zero");
endmodule

bind eeprom_access_controller eac_checker #(.WRITE_OSC_CYCLES(WRITE_OSC_CYCLES)) u_chk (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .system_reset, .sleep_power_down, .osc_run,
  .nvm_ready_irq);

// File: testbench/eeprom_access_controller_test.sv
// Purpose: Self-checking bench of the access controller.
// Assumes: A short write time of four oscillator ticks.
// Notes: Loop data and all loop addresses but the first are random from a fixed seed.
`include "eac_params.svh"

module eeprom_access_controller_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, system_reset, sleep_power_down;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, cpu_stall, osc_run, nvm_ready_irq;
  logic [8:0] a;
  logic [7:0] d;
  int fail_count, checked;
  eeprom_access_controller #(.WRITE_OSC_CYCLES(4)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .system_reset, .sleep_power_down, .cpu_stall,
    .osc_run, .nvm_ready_irq);
  eac_nvm_model nvm_ref ();
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic hold;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) begin
      fail_count++;
      close_out();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, ad};
    hwrite <= w;
    hold();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    hold();
    rd = hrdata;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      xfer(1'b0, `EAC_OFS_CTRL, 32'h0);
      n++;
    end while (rd[1] !== 1'b0 && n < 60);
    check({31'h0, rd[1]}, 32'h0);
    if (rd[1] !== 1'b0) begin
      close_out();
    end
  endtask
  task automatic set_addr(input logic [8:0] ad);
    xfer(1'b1, `EAC_OFS_ADDR_HI, {31'h0, ad[8]});
    xfer(1'b1, `EAC_OFS_ADDR_LO, {24'h0, ad[7:0]});
  endtask
  task automatic start_write(input logic [8:0] ad, input logic [7:0] wd);
    wait_idle();
    set_addr(ad);
    xfer(1'b1, `EAC_OFS_DATA, {24'h0, wd});
    xfer(1'b1, `EAC_OFS_CTRL, 32'hc);
    xfer(1'b1, `EAC_OFS_CTRL, 32'ha);
    @(posedge hclk);
    check({31'h0, cpu_stall}, 32'h1);
    nvm_ref.mem[ad] = wd;
  endtask
  task automatic read_back(input logic [8:0] ad);
    wait_idle();
    set_addr(ad);
    xfer(1'b1, `EAC_OFS_CTRL, 32'h1);
    @(posedge hclk);
    check({31'h0, cpu_stall}, 32'h1);
    xfer(1'b0, `EAC_OFS_DATA, 32'h0);
    check(rd, {24'h0, nvm_ref.mem[ad]});
  endtask
  initial begin
    {hresetn, hsel, hwrite, system_reset, sleep_power_down, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    fail_count = 0;
    checked = 0;
    void'($urandom(96));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, `EAC_OFS_CTRL, 32'h0);
    check(rd, 32'h0);
    xfer(1'b1, 8'h10, 32'hff);
    xfer(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 9'h1ff : 9'($urandom);
      d = 8'($urandom);
      start_write(a, d);
      xfer(1'b0, `EAC_OFS_CTRL, 32'h0);
      check(rd & 32'h2, 32'h2);
      check({31'h0, nvm_ready_irq}, 32'h0);
      xfer(1'b1, `EAC_OFS_ADDR_LO, {24'h0, ~a[7:0]});
      xfer(1'b1, `EAC_OFS_CTRL, 32'h1);
      xfer(1'b0, `EAC_OFS_DATA, 32'h0);
      check(rd, {24'h0, d});
      xfer(1'b0, `EAC_OFS_ADDR_LO, 32'h0);
      check(rd, {24'h0, a[7:0]});
      wait_idle();
      xfer(1'b0, `EAC_OFS_ADDR_HI, 32'h0);
      check(rd, {31'h0, a[8]});
      read_back(a);
    end
    xfer(1'b1, `EAC_OFS_CTRL, 32'h4);
    xfer(1'b0, `EAC_OFS_CTRL, 32'h0);
    check(rd & 32'h4, 32'h4);
    repeat (4) @(posedge hclk);
    xfer(1'b0, `EAC_OFS_CTRL, 32'h0);
    check(rd & 32'h4, 32'h0);
    xfer(1'b1, `EAC_OFS_CTRL, 32'h2);
    xfer(1'b0, `EAC_OFS_CTRL, 32'h0);
    check(rd & 32'h2, 32'h0);
    start_write(9'h0a5, 8'h3c);
    sleep_power_down <= 1'b1;
    wait_idle();
    check({31'h0, osc_run}, 32'h1);
    sleep_power_down <= 1'b0;
    repeat (3) @(posedge hclk);
    check({31'h0, osc_run}, 32'h0);
    read_back(9'h0a5);
    wait_idle();
    sleep_power_down <= 1'b1;
    repeat (2) @(posedge hclk);
    check({31'h0, osc_run}, 32'h0);
    sleep_power_down <= 1'b0;
    start_write(9'h100, 8'hc3);
    repeat (2) @(posedge hclk);
    system_reset <= 1'b1;
    @(posedge hclk);
    system_reset <= 1'b0;
    read_back(9'h100);
    close_out();
  end
endmodule
